// ### src/hbw_host_glue.sv
// hbw_host_glue: byte-wide host controller driving a word-wide device host port
// assumes the device runs generic 16-bit mode, samples straps when its reset rises,
// and stretches each access with an active-low wait output
//
// Overview of operation
// - no processor clock exists here, so a free-running divider supplies the bus clock
// - all seventeen address lines and the data lines go straight to the device
// - the host byte appears on both device byte lanes
// - chip select is active low, only for addresses inside the decoded window
// - upper byte select is the inverse of address bit zero
// - bus status and read/write straps stay high, never driven by accesses
// - read strobe drives device read, write strobe drives device low write strobe
// - device wait feeds the host wait; host reset drops device reset at once, release follows DEV_RESET_CYC clocks later
// - without address bit sixteen only part of display memory is reachable
// - only read, write, wait, chip select, upper byte select, address and data take part in an access
// - the strobe stays on while wait is low until WAIT_LIMIT_BCLK + 1 bus clocks; cycle ends once wait releases after STROBE_MIN_BCLK bus clocks, or at that limit
// - device wait is active low; invert only for an active-high host wait
`timescale 1ns/1ps
module hbw_host_glue (
   input  wire logic                                I_MCLK,
   input  wire logic                                I_RST_N,
   input  wire logic                                I_ENDIAN_BIG,
   input  wire logic                                I_REQ_VALID,
   input  wire hbw_pkg::hbw_req_t                   I_REQ,
   output logic                                     O_REQ_READY,
   output logic                                     O_RSP_VALID,
   output hbw_pkg::hbw_rsp_t                        O_RSP,
   output logic                                     O_HOST_BUS_CLOCK,
   output logic [hbw_pkg::DEV_ADDR_W-1:0]           O_DEVICE_ADDRESS_INPUTS,
   output logic [15:0]                              O_DEVICE_DATA_LINES,
   output logic                                     O_DEVICE_DATA_OE,
   input  wire logic [15:0]                         I_DEVICE_DATA_LINES,
   output logic                                     O_CS_N,
   output logic                                     O_UPPER_BYTE_SELECT_N,
   output logic                                     O_RD_N,
   output logic                                     O_LOW_WRITE_STROBE_N,
   input  wire logic                                I_WAIT_N,
   output logic                                     O_DEV_RESET_N,
   output logic                                     O_BUS_STATUS_STRAP,
   output logic                                     O_RDWR_STRAP,
   output logic                                     O_ENDIAN_STRAP,
   output logic [2:0]                               O_CONFIG_STRAPS
);

   typedef enum logic [2:0] {
      ST_RESET,
      ST_IDLE,
      ST_ALIGN,
      ST_SETUP,
      ST_STROBE,
      ST_RECOVER
   } hbw_state_t;

   hbw_state_t                    state;
   hbw_pkg::hbw_req_t             req;
   hbw_pkg::hbw_pins_t            next_pins;
   logic [hbw_pkg::DIV_W-1:0]     div_cnt;
   logic                          bclk_fall;
   logic [hbw_pkg::RST_CNT_W-1:0] rst_cnt;
   logic [hbw_pkg::BCNT_W-1:0]    bcnt;
   logic                          wait_n_sync;
   logic [15:0]                   data_sync;
   logic                          take;
   logic                          in_window;
   logic                          rsp_err;

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   hbw_pin_sync #(
      .WIDTH     (1),
      .RESET_VAL (16'h0001)
   ) u_wait_sync (
      .i_clk   (I_MCLK),
      .i_rst_n (I_RST_N),
      .i_pin   (I_WAIT_N),
      .o_level (wait_n_sync)
   );

   hbw_pin_sync #(
      .WIDTH     (16),
      .RESET_VAL (16'h0000)
   ) u_data_sync (
      .i_clk   (I_MCLK),
      .i_rst_n (I_RST_N),
      .i_pin   (I_DEVICE_DATA_LINES),
      .o_level (data_sync)
   );

   // ----------------------------------------------------------------------
   // bus clock divider
   // ----------------------------------------------------------------------
   // the clock is made here, so address, data, select and strobe pins only change right after its falling edge
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         div_cnt          <= '0;
         O_HOST_BUS_CLOCK <= 1'b0;
         bclk_fall        <= 1'b0;
      end else begin
         bclk_fall <= 1'b0;
         if (div_cnt == hbw_pkg::DIV_W'(hbw_pkg::BCLK_HALF_CYC - 1)) begin
            div_cnt          <= '0;
            O_HOST_BUS_CLOCK <= ~O_HOST_BUS_CLOCK;
            bclk_fall        <= O_HOST_BUS_CLOCK;
         end else begin
            div_cnt <= div_cnt + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // device reset and straps
   // ----------------------------------------------------------------------
   // host reset drops the device reset at once; release waits for a full hold time
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_cnt       <= '0;
         O_DEV_RESET_N <= 1'b0;
      end else if (rst_cnt == hbw_pkg::RST_CNT_W'(hbw_pkg::DEV_RESET_CYC - 1)) begin
         O_DEV_RESET_N <= 1'b1;
      end else begin
         rst_cnt <= rst_cnt + 1'b1;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_BUS_STATUS_STRAP <= hbw_pkg::BUS_STATUS_VAL;
         O_RDWR_STRAP       <= hbw_pkg::RDWR_STRAP_VAL;
         O_CONFIG_STRAPS    <= hbw_pkg::CONFIG_STRAP_VAL;
         O_ENDIAN_STRAP     <= 1'b0;
      end else begin
         O_BUS_STATUS_STRAP <= hbw_pkg::BUS_STATUS_VAL;
         O_RDWR_STRAP       <= hbw_pkg::RDWR_STRAP_VAL;
         O_CONFIG_STRAPS    <= hbw_pkg::CONFIG_STRAP_VAL;
         // endian may only move while the device still holds its reset
         if (!O_DEV_RESET_N) begin
            O_ENDIAN_STRAP <= I_ENDIAN_BIG;
         end
      end
   end

   // ----------------------------------------------------------------------
   // glue: decode, lane replication, upper select
   // ----------------------------------------------------------------------
   // these feed the pin flops directly, so the pins carry no extra stage
   always_comb begin
      in_window         = (I_REQ.addr[hbw_pkg::HOST_ADDR_W-1:hbw_pkg::DEV_ADDR_W] ==
                           hbw_pkg::WINDOW_SEL);
      next_pins.addr    = req.addr[hbw_pkg::DEV_ADDR_W-1:0];
      next_pins.data    = {req.wdata, req.wdata};
      next_pins.upper_n = ~req.addr[0];
      take              = I_REQ_VALID && O_REQ_READY;
   end

   // ----------------------------------------------------------------------
   // access sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state                   <= ST_RESET;
         req                     <= '0;
         bcnt                    <= '0;
         rsp_err                 <= 1'b0;
         O_REQ_READY             <= 1'b0;
         O_RSP_VALID             <= 1'b0;
         O_RSP                   <= '0;
         O_DEVICE_ADDRESS_INPUTS <= '0;
         O_DEVICE_DATA_LINES     <= '0;
         O_DEVICE_DATA_OE        <= 1'b0;
         O_CS_N                  <= 1'b1;
         O_UPPER_BYTE_SELECT_N   <= 1'b1;
         O_RD_N                  <= 1'b1;
         O_LOW_WRITE_STROBE_N    <= 1'b1;
      end else begin
         O_RSP_VALID <= 1'b0;
         unique case (state)
            ST_RESET: begin
               if (O_DEV_RESET_N && bclk_fall) begin
                  state       <= ST_IDLE;
                  O_REQ_READY <= 1'b1;
               end
            end
            ST_IDLE: begin
               if (take) begin
                  req <= I_REQ;
                  if (in_window) begin
                     state       <= ST_ALIGN;
                     O_REQ_READY <= 1'b0;
                  end else begin
                     // outside the window: refused without touching the pins
                     O_RSP_VALID   <= 1'b1;
                     O_RSP.err     <= 1'b1;
                     O_RSP.reg_hit <= 1'b0;
                     O_RSP.rdata   <= '0;
                  end
               end
            end
            ST_ALIGN: begin
               if (bclk_fall) begin
                  O_DEVICE_ADDRESS_INPUTS <= next_pins.addr;
                  O_DEVICE_DATA_LINES     <= next_pins.data;
                  O_UPPER_BYTE_SELECT_N   <= next_pins.upper_n;
                  O_DEVICE_DATA_OE        <= req.write;
                  O_CS_N                  <= 1'b0;
                  state                   <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (bclk_fall) begin
                  // only read and write strobes move; chip select, upper select, address and data were set in ST_ALIGN
                  O_RD_N               <= req.write;
                  O_LOW_WRITE_STROBE_N <= ~req.write;
                  bcnt                 <= '0;
                  rsp_err              <= 1'b0;
                  state                <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               if (bclk_fall) begin
                  bcnt <= bcnt + 1'b1;
                  // the device needs time to pull wait low, so it is not looked at at once
                  if (bcnt >= hbw_pkg::BCNT_W'(hbw_pkg::STROBE_MIN_BCLK - 1) &&
                      (wait_n_sync || bcnt == hbw_pkg::BCNT_W'(hbw_pkg::WAIT_LIMIT_BCLK))) begin
                     rsp_err              <= !wait_n_sync;
                     O_RSP.rdata          <= req.addr[0] ? data_sync[15:8] : data_sync[7:0];
                     O_RD_N               <= 1'b1;
                     O_LOW_WRITE_STROBE_N <= 1'b1;
                     state                <= ST_RECOVER;
                  end
               end
            end
            ST_RECOVER: begin
               if (bclk_fall) begin
                  O_CS_N                <= 1'b1;
                  O_DEVICE_DATA_OE      <= 1'b0;
                  O_UPPER_BYTE_SELECT_N <= 1'b1;
                  O_RSP_VALID           <= 1'b1;
                  O_RSP.err             <= rsp_err;
                  O_RSP.reg_hit         <= (req.addr[hbw_pkg::DEV_ADDR_W-1:0] >= hbw_pkg::REG_BASE);
                  if (req.write) begin
                     O_RSP.rdata <= '0;
                  end
                  O_REQ_READY           <= 1'b1;
                  state                 <= ST_IDLE;
               end
            end
         endcase
      end
   end

endmodule

// ### src/hbw_pkg.sv
// hbw_pkg: constants and carrier types for the byte host to word bus glue
// assumes a 200 MHz system clock and a word-wide device host port in generic 16-bit mode
package hbw_pkg;

   // ----------------------------------------------------------------------
   // clocking
   // ----------------------------------------------------------------------
   localparam int MCLK_PERIOD_NS  = 5;
   localparam int BCLK_PERIOD_NS  = 80;
   // half period of the generated bus clock, rounded down, never below one cycle
   localparam int BCLK_HALF_CYC   = (BCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS)) < 1 ? 1 :
                                    (BCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS));
   localparam int DIV_W           = 4;

   // ----------------------------------------------------------------------
   // device reset and bus cycle shaping
   // ----------------------------------------------------------------------
   localparam int DEV_RESET_NS    = 2000;
   localparam int DEV_RESET_CYC   = (DEV_RESET_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int RST_CNT_W       = 9;
   localparam int STROBE_MIN_BCLK = 2;
   localparam int WAIT_LIMIT_BCLK = 255;
   localparam int BCNT_W          = 8;

   // ----------------------------------------------------------------------
   // address map
   // ----------------------------------------------------------------------
   localparam int HOST_ADDR_W     = 20;
   localparam int DEV_ADDR_W      = 17;
   localparam int SEL_W           = HOST_ADDR_W - DEV_ADDR_W;
   localparam logic [SEL_W-1:0]      WINDOW_SEL = 3'h1;
   localparam logic [DEV_ADDR_W-1:0] REG_BASE   = 17'h1_ffe0;

   // ----------------------------------------------------------------------
   // strap levels held on the device pins
   // ----------------------------------------------------------------------
   localparam logic [2:0] CONFIG_STRAP_VAL = 3'h7;
   localparam logic       BUS_STATUS_VAL   = 1'h1;
   localparam logic       RDWR_STRAP_VAL   = 1'h1;

   // ----------------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic                   write;
      logic [HOST_ADDR_W-1:0] addr;
      logic [7:0]             wdata;
   } hbw_req_t;

   typedef struct packed {
      logic       err;
      logic       reg_hit;
      logic [7:0] rdata;
   } hbw_rsp_t;

   typedef struct packed {
      logic [DEV_ADDR_W-1:0] addr;
      logic [15:0]           data;
      logic                  upper_n;
   } hbw_pins_t;

endpackage

// ### src/hbw_pin_sync.sv
// hbw_pin_sync: three-stage synchroniser for pins from outside the clock domain
// assumes nothing of the source; a change is taken once stages two and three agree
`timescale 1ns/1ps
module hbw_pin_sync #(
   parameter int          WIDTH     = 1,
   parameter logic [15:0] RESET_VAL = 16'h0000
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_pin,
   output logic      [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // ----------------------------------------------------------------------
   // per-bit chain
   // ----------------------------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : g_bit
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               stage1[b]  <= RESET_VAL[b];
               stage2[b]  <= RESET_VAL[b];
               stage3[b]  <= RESET_VAL[b];
               o_level[b] <= RESET_VAL[b];
            end else begin
               stage1[b] <= i_pin[b];
               stage2[b] <= stage1[b];
               stage3[b] <= stage2[b];
               // a single-cycle glitch past stage one never reaches the output
               if (stage2[b] == stage3[b]) begin
                  o_level[b] <= stage3[b];
               end
            end
         end
      end
   endgenerate

endmodule

// ### testbench/hbw_dev_model.sv
// hbw_dev_model: behavioural word-wide device as seen at the glue's pins
// assumes pins settle before each bus clock rise; the store is small and aliased
`timescale 1ns/1ps
module hbw_dev_model (
   input  wire logic        i_bclk,
   input  wire logic        i_rst_n,
   input  wire logic [16:0] i_addr,
   input  wire logic [15:0] i_d,
   input  wire logic        i_cs_n,
   input  wire logic        i_ub_n,
   input  wire logic        i_rd_n,
   input  wire logic        i_we_n,
   input  wire logic [4:0]  i_strap,
   input  wire logic [7:0]  i_wait_len,
   output logic      [15:0] o_d,
   output logic             o_wait_n,
   output logic      [4:0]  o_strap_cap
);
   logic [15:0] mem [32];
   logic [15:0] last;
   logic [7:0]  cnt;
   logic [4:0]  idx;
   logic        act;
   // aliased across the 128 Kbyte block, registers included
   assign idx      = i_addr[5:1];
   assign act      = !i_cs_n && !(i_rd_n && i_we_n);
   assign o_wait_n = !(act && cnt < i_wait_len);
   // released lines show the inverse of the last word so a stale value never passes
   assign o_d      = (act && !i_rd_n) ? mem[idx] : ~last;
   initial begin
      cnt  = 8'h00;
      last = 16'h0000;
      foreach (mem[i]) mem[i] = 16'hc3c3;
   end
   always @(posedge i_rst_n) o_strap_cap <= i_strap;
   always @(posedge i_bclk) begin
      cnt <= act ? cnt + 8'h01 : 8'h00;
      if (act && !i_rd_n) last <= mem[idx];
      // a write lands on the edge that releases wait; the strobe is gone by the next one
      if (act && !i_we_n && cnt + 8'h01 >= i_wait_len && !i_ub_n) mem[idx][15:8] <= i_d[15:8];
      if (act && !i_we_n && cnt + 8'h01 >= i_wait_len && i_ub_n) mem[idx][7:0] <= i_d[7:0];
   end
endmodule

// ### testbench/hbw_host_glue_properties.sv
// hbw_host_glue_properties: pin and handshake checks of the byte host glue
// assumes it is bound into hbw_host_glue and sees only its ports
`timescale 1ns/1ps
module hbw_host_glue_properties (
   input wire logic                           I_MCLK,
   input wire logic                           I_RST_N,
   input wire logic                           I_REQ_VALID,
   input wire hbw_pkg::hbw_req_t              I_REQ,
   input wire logic                           O_REQ_READY,
   input wire logic                           O_RSP_VALID,
   input wire hbw_pkg::hbw_rsp_t              O_RSP,
   input wire logic                           O_HOST_BUS_CLOCK,
   input wire logic [hbw_pkg::DEV_ADDR_W-1:0] O_DEVICE_ADDRESS_INPUTS,
   input wire logic [15:0]                    O_DEVICE_DATA_LINES,
   input wire logic                           O_DEVICE_DATA_OE,
   input wire logic                           O_CS_N,
   input wire logic                           O_UPPER_BYTE_SELECT_N,
   input wire logic                           O_RD_N,
   input wire logic                           O_LOW_WRITE_STROBE_N,
   input wire logic                           I_WAIT_N
);
   logic st;
   logic take;
   assign st   = !O_RD_N || !O_LOW_WRITE_STROBE_N;
   assign take = I_REQ_VALID && O_REQ_READY;
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);
   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   bclk_period_a: assert property ($rose(O_HOST_BUS_CLOCK) |-> O_HOST_BUS_CLOCK[*8] ##1 !O_HOST_BUS_CLOCK[*8])
      else $error("bus clock period wrong");
   pin_edge_a: assert property ($changed(O_CS_N) || $changed(O_RD_N) || $changed(O_LOW_WRITE_STROBE_N)
      |-> !$past(O_HOST_BUS_CLOCK) && $past(O_HOST_BUS_CLOCK, 2)) else $error("strobe moved off bus clock fall");
   upper_sel_a: assert property (!O_CS_N |-> O_UPPER_BYTE_SELECT_N == !O_DEVICE_ADDRESS_INPUTS[0])
      else $error("upper select not inverse of a0");
   lane_copy_a: assert property (O_DEVICE_DATA_OE |-> O_DEVICE_DATA_LINES[15:8] == O_DEVICE_DATA_LINES[7:0])
      else $error("byte lanes differ");
   strobe_cs_a: assert property (O_CS_N |-> O_RD_N && O_LOW_WRITE_STROBE_N)
      else $error("strobe without chip select");
   rd_no_drive_a: assert property (!O_RD_N |-> O_LOW_WRITE_STROBE_N && !O_DEVICE_DATA_OE)
      else $error("read with write strobe or drive");
   wait_hold_a: assert property ((st && !I_WAIT_N)[*6] |=> st)
      else $error("strobe dropped while wait low");
   strobe_min_a: assert property ($rose(st) |-> ##31 st)
      else $error("strobe too short");
   miss_err_a: assert property (take && I_REQ.addr[19:17] != hbw_pkg::WINDOW_SEL
      |=> O_RSP_VALID && O_RSP.err && O_CS_N) else $error("miss not refused at once");
   hit_sel_a: assert property (take && I_REQ.addr[19:17] == hbw_pkg::WINDOW_SEL |-> ##[1:20] !O_CS_N)
      else $error("window hit not selected");
   cover property ($fell(O_RD_N));
   cover property ($fell(O_LOW_WRITE_STROBE_N));
   cover property (O_RSP_VALID && O_RSP.err);
endmodule
bind hbw_host_glue hbw_host_glue_properties u_props (.*);

// ### testbench/hbw_host_glue_tb.sv
// hbw_host_glue_tb: table of byte accesses through the glue into a device model
// assumes a 200 MHz clock; rows run in order since reads expect earlier writes
`timescale 1ns/1ps
module hbw_host_glue_tb;
   typedef struct packed {
      logic        w;
      logic [19:0] a;
      logic [7:0]  d;
      logic        err;
      logic        hit;
   } hbw_row_t;
   logic              clk, rst_n, endian, req_v, rdy, rsp_v, bclk, oe, cs_n, ub_n, rd_n, we_n, wait_n;
   logic              drst_n, bs, rdwr, end_s;
   logic [2:0]        cfg;
   logic [4:0]        cap;
   logic [7:0]        wlen;
   logic [15:0]       dout, din, m_d;
   logic [16:0]       addr;
   hbw_pkg::hbw_req_t req;
   hbw_pkg::hbw_rsp_t rsp, rs;
   int                error_cnt, n_checks, lat, n;
   hbw_row_t          rows [10] = '{
      '{1'h1, 20'h2_0000, 8'ha5, 1'h0, 1'h0}, '{1'h1, 20'h2_0001, 8'h3c, 1'h0, 1'h0},
      '{1'h0, 20'h2_0000, 8'ha5, 1'h0, 1'h0}, '{1'h0, 20'h2_0001, 8'h3c, 1'h0, 1'h0},
      '{1'h1, 20'h3_ffe1, 8'h5a, 1'h0, 1'h1}, '{1'h0, 20'h3_ffe1, 8'h5a, 1'h0, 1'h1},
      '{1'h1, 20'h3_ffdf, 8'h77, 1'h0, 1'h0}, '{1'h0, 20'h3_ffdf, 8'h77, 1'h0, 1'h0},
      '{1'h0, 20'h1_0000, 8'h00, 1'h1, 1'h0}, '{1'h1, 20'h4_0000, 8'h11, 1'h1, 1'h0}};
   // the data pins carry whichever side drives them
   assign din = oe ? dout : m_d;
   hbw_host_glue DUT (.I_MCLK(clk), .I_RST_N(rst_n), .I_ENDIAN_BIG(endian), .I_REQ_VALID(req_v),
      .I_REQ(req), .O_REQ_READY(rdy), .O_RSP_VALID(rsp_v), .O_RSP(rsp), .O_HOST_BUS_CLOCK(bclk),
      .O_DEVICE_ADDRESS_INPUTS(addr), .O_DEVICE_DATA_LINES(dout), .O_DEVICE_DATA_OE(oe),
      .I_DEVICE_DATA_LINES(din), .O_CS_N(cs_n), .O_UPPER_BYTE_SELECT_N(ub_n), .O_RD_N(rd_n),
      .O_LOW_WRITE_STROBE_N(we_n), .I_WAIT_N(wait_n), .O_DEV_RESET_N(drst_n), .O_BUS_STATUS_STRAP(bs),
      .O_RDWR_STRAP(rdwr), .O_ENDIAN_STRAP(end_s), .O_CONFIG_STRAPS(cfg));
   hbw_dev_model u_dev (.i_bclk(bclk), .i_rst_n(drst_n), .i_addr(addr), .i_d(din), .i_cs_n(cs_n),
      .i_ub_n(ub_n), .i_rd_n(rd_n), .i_we_n(we_n), .i_strap({bs, end_s, cfg}), .i_wait_len(wlen),
      .o_d(m_d), .o_wait_n(wait_n), .o_strap_cap(cap));
   // ----------------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------------
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // request held until taken; response pulse is looked at on the edge that ends it
   task xfer(input hbw_row_t r);
      req = '{r.w, r.a, r.d};
      req_v = 1'h1;
      n = 0;
      do begin @(posedge clk); n++; end while (rdy !== 1'h1 && n < 5000);
      #1 req_v = 1'h0;
      lat = 0;
      do begin @(posedge clk); lat++; end while (rsp_v !== 1'h1 && lat < 6000);
      rs = rsp;
      #1;
      if (n >= 5000 || lat >= 6000) begin
         error_cnt++;
         $display("BAD xfer exp done seen timeout");
         stop_test;
      end
   endtask
   task do_reset(input logic e);
      rst_n = 1'h0;
      endian = e;
      repeat (3) @(posedge clk);
      #1;
      check("rst_cs", cs_n, 1);
      check("rst_strobes", {rd_n, we_n}, 2'h3);
      check("rst_dev", drst_n, 0);
      rst_n = 1'h1;
      n = 0;
      do begin @(posedge clk); #1; n++; end while (drst_n !== 1'h1 && n < 1000);
      check("dev_rst_len", n inside {[hbw_pkg::DEV_RESET_CYC-1 : hbw_pkg::DEV_RESET_CYC+1]}, 1);
      check("strap_cap", cap, {1'h1, e, 3'h7});
      check("rdwr_strap", rdwr, 1);
      endian = ~e;
      repeat (2) @(posedge clk);
      #1;
      check("endian_frozen", end_s, e);
      $display("test reset done");
   endtask
   // ----------------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------------
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      error_cnt = 0;
      n_checks = 0;
      rst_n = 1'h0;
      endian = 1'h1;
      req_v = 1'h0;
      req = '0;
      wlen = 8'h00;
      do_reset(1'h1);
      foreach (rows[i]) begin
         xfer(rows[i]);
         check("err", rs.err, rows[i].err);
         if (rows[i].err) check("miss_lat", lat, 1);
         else check("reg_hit", rs.reg_hit, rows[i].hit);
         if (!rows[i].err) check("rdata", rs.rdata, rows[i].w ? 8'h00 : rows[i].d);
         if (!rows[i].err) check("addr", addr, rows[i].a[16:0]);
         $display("test row %0d done", i);
      end
      // slow device: wait held low for six bus clocks
      wlen = 8'h06;
      xfer(hbw_row_t'{1'h1, 20'h2_0002, 8'h96, 1'h0, 1'h0});
      check("slow_lat", lat > 96, 1);
      xfer(hbw_row_t'{1'h0, 20'h2_0002, 8'h96, 1'h0, 1'h0});
      check("slow_rd", rs.rdata, 8'h96);
      $display("test slow wait done");
      // reset in mid read, strapping the other endian
      req = '{1'h0, 20'h2_0000, 8'h00};
      req_v = 1'h1;
      n = 0;
      do begin @(posedge clk); n++; end while (rd_n !== 1'h0 && n < 200);
      #1 req_v = 1'h0;
      check("mid_rd", rd_n, 0);
      do_reset(1'h0);
      xfer(rows[2]);
      check("post_rd", rs.rdata, 8'ha5);
      $display("test mid reset done");
      stop_test;
   end
endmodule
